// ### pss_pkg.sv
// package: register map, field layout and reset values of the synthesizer control block
package pss_pkg;

	// ==========================================================
	// register map (printed offsets are indices, byte = 4x index)
	localparam logic [31:0] CTRL_IDX    = 32'h00c3_0000;  // control index
	localparam logic [31:0] STAT_IDX    = 32'h00c3_0002;  // status index
	localparam logic [31:0] CTRL_ADDR   = 32'(CTRL_IDX * 4);
	localparam logic [31:0] STAT_ADDR   = 32'(STAT_IDX * 4);

	// ==========================================================
	// control field positions
	localparam int CTL_LOL_RST  = 15;  // loss-of-lock reset enable, stored only
	localparam int CTL_MULT_HI  = 14;  // feedback_mult_sel msb
	localparam int CTL_MULT_LO  = 12;  // feedback_mult_sel lsb
	localparam int CTL_FRST     = 11;  // clock_fail_reset_en
	localparam int CTL_DIV_HI   = 10;  // post_divider_sel msb
	localparam int CTL_DIV_LO   = 8;   // post_divider_sel lsb
	localparam int CTL_FDET     = 7;   // clock_fail_detect_en
	localparam int CTL_OUT_DIS  = 6;   // clock_out_disable
	localparam int CTL_FWAKE    = 5;   // fast_wake
	localparam int CTL_STOP_HI  = 3;   // stop_clock_policy msb
	localparam int CTL_STOP_LO  = 2;   // stop_clock_policy lsb
	localparam int CTL_WIDTH    = 16;  // control register width

	// control reset: multiplier 010, divider 001
	localparam logic [CTL_WIDTH-1:0] CTL_RESET = 16'h2100;

	// ==========================================================
	// status field positions
	localparam int ST_MODE   = 7;  // synth_mode_flag
	localparam int ST_NSEL   = 6;  // synth_normal_sel
	localparam int ST_REF    = 5;  // synth_ref_sel
	localparam int ST_LOCK_STICKY  = 4;  // lock_sticky
	localparam int ST_LOCK   = 3;  // live lock
	localparam int ST_FAIL   = 2;  // clock_fail_sticky
	localparam int ST_WIDTH  = 8;  // status register width

	// ==========================================================
	// stop policy encodings
	localparam logic [1:0] STOP_ALL_ON  = 2'h0;  // pll, osc, clock out on
	localparam logic [1:0] STOP_OUT_OFF = 2'h1;  // clock out off
	localparam logic [1:0] STOP_PLL_OFF = 2'h2;  // pll off as well
	localparam logic [1:0] STOP_OSC_OFF = 2'h3;  // oscillator off as well

	// ==========================================================
	// axi responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	// ==========================================================
	// synchroniser lanes
	localparam int SY_LOCK  = 0;  // analog lock detect
	localparam int SY_FAIL  = 1;  // analog loss of clock
	localparam int SY_OSC   = 2;  // oscillator running
	localparam int SY_MODE  = 3;  // clock mode strap
	localparam int SY_NSEL  = 4;  // normal pll strap
	localparam int SY_REF   = 5;  // crystal reference strap
	localparam int SY_WIDTH = 6;

	// clock mode straps latched during reset
	typedef struct packed {
		logic mode;   // 1 pll, 0 external
		logic nsel;   // 1 normal pll, 0 one-to-one
		logic ref_x;  // 1 crystal reference
	} pss_mode_t;

	// wakeup sequencer states
	typedef enum logic [1:0] {
		ST_RUN  = 2'b00,
		ST_STOP = 2'b01,
		ST_WAKE = 2'b10
	} pss_state_t;

endpackage

// ### pss_sync.sv
// two flip-flop synchroniser for a vector of independent levels
`timescale 1ns/1ns
module pss_sync #(
	parameter int W = 1
) (
	input  wire logic         aclk,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	// ==========================================================
	// stages
	logic [W-1:0] meta_q;  // first stage, read only by second stage

	// each lane is a level, so bits may skew by a cycle between lanes;
	// no reset, so the clock mode straps flow through while reset is held
	always_ff @(posedge aclk) begin
		meta_q   <= async_in;
		sync_out <= meta_q;
	end

endmodule

// ### pss_synth_ctrl.sv
// synthesizer control and status block with axi4-lite register access
`timescale 1ns/1ns
// ==========================================================
// Overview of operation
// - fail reset only when detect enabled and fail
// - external mode ignores reset, divider, detect, wake
// - divider write touches only output divisor
// - new divisor applied at falling clock edge
// - detect enable gates clock fail, not lock
// - output disable holds clock pin low
// - fast wake enables clocks regardless of lock
// - stop policy selects clock out, pll, oscillator
// - spare control bits are plain storage
// - status read-only, writes answer okay
// - clock mode bits latched during reset
// - lock sticky armed by reset or multiplier change
// - pll-off stop keeps lock sticky value
// - sticky and live lock clear in external mode
// - live lock follows analog frequency window
// - read in event cycle returns prior flags
// - power-on reset held until lock in pll modes
// - fail sticky holds until reset, zero external
// - fast wake from full stop forces fail flag
// - fail detected only when enabled or recovering
// - output frequency from multiplier plus two, divider
// - multiplier change or pll-off stop loses lock
module pss_synth_ctrl (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite slave
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// analog synthesizer and strap pins
	input  wire logic        pll_lock_raw,
	input  wire logic        clock_fail_raw,
	input  wire logic        osc_ready_raw,
	input  wire logic        strap_mode,
	input  wire logic        strap_normal,
	input  wire logic        strap_crystal,
	// power controller, same clock
	input  wire logic        stop_mode,
	// synthesizer controls
	output logic [2:0]       feedback_mult_sel,
	output logic [2:0]       post_divider_sel,
	output logic             system_clock_out_en,
	output logic             pll_enable,
	output logic             osc_enable,
	output logic             sys_clk_enable,
	output logic             self_clocked_mode,
	output logic             reset_request
);

	// ==========================================================
	// synchronised inputs
	logic [pss_pkg::SY_WIDTH-1:0] raw_in;   // pin levels
	logic [pss_pkg::SY_WIDTH-1:0] sync_in;  // after two stages

	assign raw_in = {strap_crystal, strap_normal, strap_mode,
	                 osc_ready_raw, clock_fail_raw, pll_lock_raw};

	// the analog lock window (0.75 / 1.5 percent) lives in the synthesizer
	pss_sync #(
		.W (pss_pkg::SY_WIDTH)
	) u_sync (
		.aclk     (aclk),
		.async_in (raw_in),
		.sync_out (sync_in)
	);

	// ==========================================================
	// state
	logic [pss_pkg::CTL_WIDTH-1:0] ctl_q;       // control register
	pss_pkg::pss_mode_t            mode_q;      // latched clock mode
	pss_pkg::pss_state_t           state_q;     // stop sequencer
	pss_pkg::pss_state_t           state_d;
	logic                          lock_q;      // live lock flag
	logic                          lock_prev_q; // lock of last cycle
	logic                          lock_sticky_q;     // lock sticky
	logic                          lock_sticky_d;
	logic                          arm_q;       // next lock sets sticky
	logic                          arm_d;
	logic                          saved_q;     // sticky value before stop
	logic                          hide_q;      // sticky reads clear
	logic                          fail_q;      // fail sticky
	logic                          recov_q;     // oscillator recovering
	logic                          por_q;       // power-on hold
	logic                          stop_prev_q; // stop of last cycle

	// ==========================================================
	// control field views
	logic       pll_on;       // pll modes only
	logic [2:0] mult_f;       // multiplier code
	logic [2:0] div_f;        // divider code
	logic       frst_f;       // fail reset enable
	logic       fdet_f;       // fail detect enable
	logic       odis_f;       // clock out disable
	logic       fwake_f;      // fast wake
	logic [1:0] pol_f;        // stop clock policy
	logic       pll_off_stop; // policy turns pll off
	logic       osc_off_stop; // policy turns oscillator off

	assign pll_on       = mode_q.mode;
	assign mult_f       = ctl_q[pss_pkg::CTL_MULT_HI:pss_pkg::CTL_MULT_LO];
	assign div_f        = ctl_q[pss_pkg::CTL_DIV_HI:pss_pkg::CTL_DIV_LO];
	assign frst_f       = ctl_q[pss_pkg::CTL_FRST] & pll_on;
	assign fdet_f       = ctl_q[pss_pkg::CTL_FDET] & pll_on;
	assign odis_f       = ctl_q[pss_pkg::CTL_OUT_DIS];
	assign fwake_f      = ctl_q[pss_pkg::CTL_FWAKE] & pll_on;
	assign pol_f        = ctl_q[pss_pkg::CTL_STOP_HI:pss_pkg::CTL_STOP_LO];
	assign pll_off_stop = (pol_f == pss_pkg::STOP_PLL_OFF) |
	                      (pol_f == pss_pkg::STOP_OSC_OFF);
	assign osc_off_stop = (pol_f == pss_pkg::STOP_OSC_OFF);

	// ==========================================================
	// axi write path
	logic        aw_q;     // address held
	logic        w_q;      // data held
	logic [31:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	logic        wr_go;    // both halves present, response free
	logic        wr_ctl;   // write hits control
	logic        wr_hit;   // write hits a mapped register
	logic [pss_pkg::CTL_WIDTH-1:0] ctl_wmask;  // byte lanes to bits
	logic [pss_pkg::CTL_WIDTH-1:0] ctl_new;    // control after write
	logic        mult_chg; // write changes multiplier

	assign wr_go     = aw_q & w_q & ~s_axi_bvalid;
	assign wr_ctl    = wr_go & (awaddr_q == pss_pkg::CTRL_ADDR);
	assign wr_hit    = (awaddr_q == pss_pkg::CTRL_ADDR) |
	                   (awaddr_q == pss_pkg::STAT_ADDR);
	assign ctl_wmask = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
	// spare and stored-only bits are written like the rest
	assign ctl_new   = (ctl_q & ~ctl_wmask) |
	                   (wdata_q[pss_pkg::CTL_WIDTH-1:0] & ctl_wmask);
	assign mult_chg  = wr_ctl &
	                   (ctl_new[pss_pkg::CTL_MULT_HI:pss_pkg::CTL_MULT_LO] != mult_f);

	// channel handshakes: each half taken independently, held until used
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_q          <= 1'b0;
			w_q           <= 1'b0;
			awaddr_q      <= '0;
			wdata_q       <= '0;
			wstrb_q       <= '0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
		end else begin
			// ready is offered one cycle ahead, never while a half is held
			s_axi_awready <= ~aw_q & ~(s_axi_awvalid & s_axi_awready);
			s_axi_wready  <= ~w_q & ~(s_axi_wvalid & s_axi_wready);
			if (s_axi_awvalid & s_axi_awready) begin
				aw_q     <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end else if (wr_go) begin
				aw_q <= 1'b0;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				w_q     <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end else if (wr_go) begin
				w_q <= 1'b0;
			end
		end
	end

	// write response: status writes answer okay and change nothing
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= pss_pkg::RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_hit ? pss_pkg::RESP_OKAY
			                       : pss_pkg::RESP_DECERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// control register; divider writes touch nothing but the divisor
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctl_q <= pss_pkg::CTL_RESET;
		end else if (wr_ctl) begin
			ctl_q <= ctl_new;
		end
	end

	// ==========================================================
	// axi read path
	logic [pss_pkg::ST_WIDTH-1:0] status;  // status image
	logic                         rd_go;   // read taken this edge
	logic                         rd_hit;  // mapped address

	// flags are read from registers, so an event landing in the read
	// cycle shows on the next read
	assign status = {mode_q.mode, mode_q.nsel, mode_q.ref_x,
	                 lock_sticky_q & ~hide_q, lock_q, fail_q | recov_q,
	                 2'h0};
	assign rd_go  = s_axi_arvalid & s_axi_arready;
	assign rd_hit = (s_axi_araddr == pss_pkg::CTRL_ADDR) |
	                (s_axi_araddr == pss_pkg::STAT_ADDR);

	// read answer one cycle after address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= pss_pkg::RESP_OKAY;
		end else begin
			s_axi_arready <= ~s_axi_rvalid & ~rd_go;
			if (rd_go) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= rd_hit ? pss_pkg::RESP_OKAY
				                       : pss_pkg::RESP_DECERR;
				if (s_axi_araddr == pss_pkg::CTRL_ADDR) begin
					s_axi_rdata <= 32'(ctl_q);
				end else if (s_axi_araddr == pss_pkg::STAT_ADDR) begin
					s_axi_rdata <= 32'(status);
				end else begin
					s_axi_rdata <= '0;
				end
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ==========================================================
	// clock mode latch
	// straps are followed while reset is held and frozen at release
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_q <= {sync_in[pss_pkg::SY_MODE],
			           sync_in[pss_pkg::SY_NSEL] & sync_in[pss_pkg::SY_MODE],
			           sync_in[pss_pkg::SY_REF] & sync_in[pss_pkg::SY_NSEL]
			           & sync_in[pss_pkg::SY_MODE]};
		end
	end

	// ==========================================================
	// stop and wakeup sequencer
	logic stop_rise;   // entering stop
	logic stop_fall;   // leaving stop
	logic osc_up;      // oscillator running
	logic lock_in;     // synchronised lock

	assign stop_rise = stop_mode & ~stop_prev_q;
	assign stop_fall = ~stop_mode & stop_prev_q;
	assign osc_up    = sync_in[pss_pkg::SY_OSC];
	// external mode never lock_sticky
	assign lock_in   = sync_in[pss_pkg::SY_LOCK] & pll_on;

	// next state
	always_comb begin
		state_d = state_q;
		case (state_q)
			pss_pkg::ST_RUN: begin
				if (stop_rise) state_d = pss_pkg::ST_STOP;
			end
			pss_pkg::ST_STOP: begin
				// external mode has no wakeup period
				if (stop_fall) begin
					state_d = pll_on ? pss_pkg::ST_WAKE : pss_pkg::ST_RUN;
				end
			end
			pss_pkg::ST_WAKE: begin
				// slow wake waits for lock or a fallback clock
				if (fwake_f | lock_q | fail_q) state_d = pss_pkg::ST_RUN;
			end
			default: state_d = pss_pkg::ST_RUN;
		endcase
	end

	// sequencer registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q     <= pss_pkg::ST_RUN;
			stop_prev_q <= 1'b0;
		end else begin
			state_q     <= state_d;
			stop_prev_q <= stop_mode;
		end
	end

	// ==========================================================
	// lock flags
	// sticky logic, default holds
	always_comb begin
		lock_sticky_d = lock_sticky_q;
		arm_d   = arm_q | mult_chg;
		if (lock_q & ~lock_prev_q & arm_q) begin
			lock_sticky_d = 1'b1;
			arm_d   = mult_chg;
		end else if (~lock_q & lock_prev_q & ~hide_q &
		             ~(state_q != pss_pkg::ST_RUN & pll_off_stop)) begin
			lock_sticky_d = 1'b0;
		end
		// fast-wake mask ends: the pre-stop value returns
		if (hide_q & lock_q) begin
			lock_sticky_d = saved_q;
		end
		if (!pll_on) begin
			lock_sticky_d = 1'b0;
		end
	end

	// sticky starts set in pll modes, armed until the first lock
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lock_q      <= 1'b0;
			lock_prev_q <= 1'b0;
			lock_sticky_q     <= 1'b1;
			arm_q       <= 1'b1;
		end else begin
			lock_q      <= lock_in;
			lock_prev_q <= lock_q;
			lock_sticky_q     <= lock_sticky_d;
			arm_q       <= arm_d;
		end
	end

	// pre-stop copy of the sticky and its masking after a fast wake
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			saved_q <= 1'b0;
			hide_q  <= 1'b0;
		end else begin
			if (stop_rise) begin
				saved_q <= lock_sticky_q;
			end
			if (stop_fall & fwake_f & pll_off_stop) begin
				hide_q <= 1'b1;
			end else if (hide_q & lock_q) begin
				hide_q <= 1'b0;
			end
		end
	end

	// ==========================================================
	// loss of clock
	logic fail_seen;  // qualified failure this cycle

	// detection only while enabled or recovering from a fast wake
	assign fail_seen = sync_in[pss_pkg::SY_FAIL] & pll_on &
	                   (fdet_f | recov_q);

	// sticky fail and the temporary oscillator-recovery indication
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fail_q  <= 1'b0;
			recov_q <= 1'b0;
		end else begin
			if (fail_seen) begin
				fail_q <= 1'b1;
			end
			if (stop_fall & fwake_f & osc_off_stop) begin
				recov_q <= 1'b1;
			end else if (osc_up) begin
				recov_q <= 1'b0;
			end
		end
	end

	// ==========================================================
	// synthesizer controls
	logic in_stop;   // sequencer in stop
	logic sysclk_d;  // system clocks run

	assign in_stop  = (state_q == pss_pkg::ST_STOP);
	assign sysclk_d = (state_q == pss_pkg::ST_RUN) |
	                  ((state_q == pss_pkg::ST_WAKE) & (fwake_f | lock_q));

	// enables for the analog side
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			feedback_mult_sel   <= pss_pkg::CTL_RESET[pss_pkg::CTL_MULT_HI:
			                                           pss_pkg::CTL_MULT_LO];
			system_clock_out_en <= 1'b0;
			pll_enable          <= 1'b0;
			osc_enable          <= 1'b0;
			sys_clk_enable      <= 1'b0;
			self_clocked_mode   <= 1'b0;
		end else begin
			// the synthesizer drops lock on a new multiplier
			feedback_mult_sel   <= mult_f;
			system_clock_out_en <= ~odis_f &
			                       ~(in_stop & (pol_f != pss_pkg::STOP_ALL_ON));
			pll_enable          <= pll_on & ~(in_stop & pll_off_stop);
			osc_enable          <= ~(in_stop & osc_off_stop);
			sys_clk_enable      <= sysclk_d & ~stop_mode;
			self_clocked_mode   <= recov_q | (fail_q & ~fwake_f);
		end
	end

	// divisor applied on the falling edge so the change lands cleanly
	// in the clock currently running; external mode pins it at zero
	always_ff @(negedge aclk) begin
		if (!aresetn) begin
			post_divider_sel <= pss_pkg::CTL_RESET[pss_pkg::CTL_DIV_HI:
			                                        pss_pkg::CTL_DIV_LO];
		end else begin
			post_divider_sel <= pll_on ? div_f : 3'h0;
		end
	end

	// ==========================================================
	// reset requests
	// power-on hold lasts until the first lock in pll modes; software
	// must drop the fail reset enable before a pll-off stop
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			por_q         <= 1'b1;
			reset_request <= 1'b0;
		end else begin
			if (lock_q | ~pll_on) begin
				por_q <= 1'b0;
			end
			reset_request <= (por_q & pll_on & ~lock_q) |
			                 (frst_f & fdet_f & (fail_q | recov_q));
		end
	end

endmodule

// ### pss_synth_ctrl_asserts.sv
// checker: bus handshake and clock control relations at the ports
`timescale 1ns/1ns
module pss_chk (
	input wire logic        aclk, aresetn, s_axi_awvalid, s_axi_awready,
	input wire logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready,
	input wire logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
	input wire logic        pll_lock_raw, stop_mode, sys_clk_enable, reset_request,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic [2:0]  feedback_mult_sel,
	input wire logic [31:0] s_axi_rdata
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ==========================================================
	// bus answers, held until taken
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp not held");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata not held");
	a_read_next: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid) else $error("read answer late");
	a_arready_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("address taken while busy");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
	// ==========================================================
	// clock control
	a_reset_idle: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid
		&& !reset_request) else $error("outputs busy after reset");
	a_mult_reset: assert property ($rose(aresetn) |-> feedback_mult_sel == 3'h2)
		else $error("multiplier reset code wrong");
	a_stop_clocks: assert property (stop_mode [*4] |-> !sys_clk_enable)
		else $error("system clocks run in stop");
	a_lock_release: assert property ($fell(reset_request) |-> $past(pll_lock_raw, 2))
		else $error("reset released without lock");
	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_stop: cover property (stop_mode [*4]);
	c_release: cover property ($fell(reset_request));
endmodule

bind pss_synth_ctrl pss_chk i_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid, .s_axi_rready, .pll_lock_raw, .stop_mode,
	.sys_clk_enable, .reset_request, .s_axi_bresp, .feedback_mult_sel, .s_axi_rdata);

// ### tb_pss_synth_ctrl.sv
// self-checking bench for the synthesizer control block
`timescale 1ns/1ns
module tb_pss_synth_ctrl;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
	logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic        s_axi_rvalid, pll_lock_raw, clock_fail_raw, osc_ready_raw, stop_mode;
	logic        strap_mode, strap_normal, strap_crystal, system_clock_out_en;
	logic        pll_enable, osc_enable, sys_clk_enable, self_clocked_mode, reset_request;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd_q;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	logic [2:0]  feedback_mult_sel, post_divider_sel;
	int          failures, n_tests;

	pss_synth_ctrl i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pll_lock_raw,
		.clock_fail_raw, .osc_ready_raw, .strap_mode, .strap_normal, .strap_crystal,
		.stop_mode, .feedback_mult_sel, .post_divider_sel, .system_clock_out_en,
		.pll_enable, .osc_enable, .sys_clk_enable, .self_clocked_mode, .reset_request);

	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end

	task automatic chk(input string nm, input logic [31:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// ==========================================================
	// bus tasks: ready is registered, so its value at the falling edge is what the
	// next rising edge samples; bready and rready stay high for the whole run
	task automatic wr(input logic [31:0] a, d);
		logic aw, w, b;
		int n;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(negedge aclk);
			aw = s_axi_awready;
			w = s_axi_wready;
			b = s_axi_bvalid;
			rsp = s_axi_bresp;
			@(posedge aclk);
			if (aw) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
			if (b) break;
		end
		if (n == 64) begin
			failures++;
			summarize();
		end
	endtask

	task automatic rd(input logic [31:0] a);
		logic ar, r;
		int n;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(negedge aclk);
			ar = s_axi_arready;
			r = s_axi_rvalid;
			rd_q = s_axi_rdata;
			rsp = s_axi_rresp;
			@(posedge aclk);
			if (ar) s_axi_arvalid <= 1'b0;
			if (r) break;
		end
		if (n == 64) begin
			failures++;
			summarize();
		end
	endtask

	// ==========================================================
	// main sequence, normal pll mode with crystal reference
	initial begin
		failures = 0;
		n_tests = 0;
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, stop_mode} = '0;
		{pll_lock_raw, clock_fail_raw, s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
		{strap_mode, strap_normal, strap_crystal, osc_ready_raw} = 4'hf;
		{s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3f;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (6) @(negedge aclk);
		chk("hold", 32'(reset_request), 32'h1);
		@(posedge aclk);
		pll_lock_raw <= 1'b1;
		repeat (8) @(negedge aclk);
		chk("release", 32'(reset_request), 32'h0);
		rd(pss_pkg::CTRL_ADDR);
		chk("ctrl reset", rd_q, 32'h2100);
		rd(pss_pkg::STAT_ADDR);
		chk("mode", rd_q & 32'he0, 32'he0);
		chk("lock_sticky", rd_q & 32'h1c, 32'h18);
		$display("test reset done");
		wr(pss_pkg::CTRL_ADDR, 32'h2313);
		chk("wr resp", 32'(rsp), 32'(pss_pkg::RESP_OKAY));
		rd(pss_pkg::CTRL_ADDR);
		chk("spare", rd_q, 32'h2313);
		chk("div", 32'(post_divider_sel), 32'h3);
		chk("mult", 32'(feedback_mult_sel), 32'h2);
		chk("system_clock_out on", 32'(system_clock_out_en), 32'h1);
		wr(pss_pkg::CTRL_ADDR, 32'h2353);
		repeat (2) @(negedge aclk);
		chk("system_clock_out off", 32'(system_clock_out_en), 32'h0);
		wr(pss_pkg::STAT_ADDR, 32'h0);
		chk("stat wr", 32'(rsp), 32'(pss_pkg::RESP_OKAY));
		rd(pss_pkg::STAT_ADDR);
		chk("stat kept", rd_q, 32'hf8);
		rd(pss_pkg::CTRL_ADDR + 32'h10);
		chk("unmapped", 32'(rsp), 32'(pss_pkg::RESP_DECERR));
		$display("test registers done");
		@(posedge aclk);
		stop_mode <= 1'b1;
		repeat (6) @(negedge aclk);
		chk("stop clk", 32'(sys_clk_enable), 32'h0);
		chk("stop pll", 32'(pll_enable), 32'h1);
		chk("stop osc", 32'(osc_enable), 32'h1);
		@(posedge aclk);
		stop_mode <= 1'b0;
		repeat (8) @(negedge aclk);
		chk("wake clk", 32'(sys_clk_enable), 32'h1);
		chk("no scm", 32'(self_clocked_mode), 32'h0);
		$display("test stop done");
		// fast wake from a full stop; fail reset enable stays clear
		wr(pss_pkg::CTRL_ADDR, 32'h237f);
		@(posedge aclk);
		stop_mode <= 1'b1;
		osc_ready_raw <= 1'b0;
		pll_lock_raw <= 1'b0;
		repeat (6) @(negedge aclk);
		chk("off pll", 32'(pll_enable), 32'h0);
		chk("off osc", 32'(osc_enable), 32'h0);
		@(posedge aclk);
		stop_mode <= 1'b0;
		repeat (3) @(negedge aclk);
		chk("fast clk", 32'(sys_clk_enable), 32'h1);
		chk("scm", 32'(self_clocked_mode), 32'h1);
		rd(pss_pkg::STAT_ADDR);
		chk("recovering", rd_q, 32'he4);
		@(posedge aclk);
		osc_ready_raw <= 1'b1;
		pll_lock_raw <= 1'b1;
		repeat (8) @(negedge aclk);
		rd(pss_pkg::STAT_ADDR);
		chk("restored", rd_q, 32'hf8);
		$display("test fast wake done");
		// a failure seen while detection is off must leave no trace
		@(posedge aclk);
		clock_fail_raw <= 1'b1;
		repeat (6) @(negedge aclk);
		rd(pss_pkg::STAT_ADDR);
		chk("no detect", rd_q, 32'hf8);
		wr(pss_pkg::CTRL_ADDR, 32'h2393);
		repeat (6) @(negedge aclk);
		chk("no reset", 32'(reset_request), 32'h0);
		rd(pss_pkg::STAT_ADDR);
		chk("fail set", rd_q, 32'hfc);
		@(posedge aclk);
		clock_fail_raw <= 1'b0;
		wr(pss_pkg::CTRL_ADDR, 32'h2b93);
		repeat (4) @(negedge aclk);
		chk("fail reset", 32'(reset_request), 32'h1);
		rd(pss_pkg::STAT_ADDR);
		chk("fail sticky", rd_q, 32'hfc);
		$display("test clock fail done");
		summarize();
	end
endmodule
